/* File: npd_defines.vh */
/*
  constants for the nand phase decoder: address field positions,
  burst types and state timing counts.
  assumes inclusion by bare name from the design files.
*/
`ifndef NPD_DEFINES_VH
`define NPD_DEFINES_VH
`define NPD_CHIP_HI        31
`define NPD_CHIP_LO        24
`define NPD_CYC_HI         23
`define NPD_CYC_LO         21
`define NPD_RELEASE_BIT    21
`define NPD_END_VALID_BIT  20
`define NPD_PHASE_BIT      19
`define NPD_END_HI         18
`define NPD_END_LO         11
`define NPD_START_HI       10
`define NPD_START_LO       3
`define NPD_ECC_LAST_BIT   10
`define NPD_BURST_INCR     2'h1
`define NPD_STRB_RESET     8'h00
`define NPD_DATA_BEATS     4'h1
`endif

/* File: npd_fifo.v */
/*
  small synchronous fifo with valid and ready on both sides.
  assumes one clock and an asynchronous active low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module npd_fifo
#(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
)
(
  // clock and reset
  input  wire             sys_clk,
  input  wire             rst_n,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  reg             full;
  wire            push;
  wire            pop;

  // honest full and empty
  assign in_ready  = ~full; // from a flop, so the write channel ready is registered
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage
  always @(posedge sys_clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  // pointers and occupancy
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
      full   <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      if (push & ~pop)
      begin
        count <= count + 1'b1;
        full  <= (count == DEPTH[AW:0] - 1'b1);
      end
      else if (pop & ~push)
      begin
        count <= count - 1'b1;
        full  <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: npd_decoder.v */
/*
  nand phase decoder: turns one accepted axi-like request into nand
  command, address, opcode and data steps, with chip select hold,
  unmapped handling and exclusive monitor write region.
  assumes the master keeps the address and burst restrictions, that
  requests come from logic on sys_clk, and that ready_busy is a pin.
*/
`timescale 1ns/1ps
`default_nettype none
`include "npd_defines.vh"
module npd_decoder
#(
  parameter CHIPS = 2,
  parameter DEPTH = 8
)
(
  // clock and reset
  input  wire               sys_clk,
  input  wire               rst_n,
  // chip decode tie-offs
  input  wire [8*CHIPS-1:0] address_match,
  input  wire [8*CHIPS-1:0] address_mask,
  input  wire               hold_select,
  // request
  input  wire               req_valid,
  output reg                req_ready,
  input  wire               req_write,
  input  wire [31:0]        req_addr,
  input  wire [7:0]         req_len,
  input  wire [2:0]         req_size,
  input  wire [1:0]         req_burst,
  input  wire               req_excl_fail,
  // write data
  input  wire               wr_valid,
  output wire               wr_ready,
  input  wire [63:0]        wr_data,
  input  wire [7:0]         wr_strb,
  // answer
  output reg                resp_valid,
  output reg                resp_data_phase,
  output reg                resp_unmapped,
  // nand side steps
  output reg                nand_cmd_valid,
  output reg  [7:0]         nand_cmd,
  output reg                nand_addr_valid,
  output reg  [7:0]         nand_addr,
  output reg                nand_data_valid,
  output reg  [63:0]        nand_wdata,
  output reg  [7:0]         nand_strb,
  output reg  [CHIPS-1:0]   chip_select,
  output reg                if0_async,
  output reg                bus_request,
  output reg                ecc_last,
  // ready busy and status
  input  wire               ready_busy,
  output reg                raw_ready_status,
  input  wire               status_clear,
  // exclusive monitor region
  output reg  [31:0]        excl_cmp_mask,
  output reg  [31:0]        excl_cmp_addr
);
  localparam ST_IDLE = 5'h01;
  localparam ST_CMD  = 5'h02;
  localparam ST_ADDR = 5'h04;
  localparam ST_DATA = 5'h08;
  localparam ST_END  = 5'h10;

  reg  [4:0]       state;
  reg  [31:0]      addr;
  reg              is_write;
  reg              unmapped;
  reg  [2:0]       cyc_left;
  reg  [7:0]       beats_left;
  reg  [2:0]       byte_idx;
  reg              held;
  reg              rb_s1;
  reg              rb_s2;
  reg              rb_d;
  wire [CHIPS-1:0] hit;
  wire             f_valid;
  wire             f_ready;
  wire [71:0]      f_data;
  wire [7:0]       f_strb;
  wire [7:0]       lane_mask;
  wire [31:0]      wr_last;
  wire [31:0]      diff;
  wire             take;
  reg  [31:0]      next_mask;
  integer          k;

  // chip decode per chip
  genvar g;
  generate
    for (g = 0; g < CHIPS; g = g + 1)
    begin : g_chip
      assign hit[g] = ((req_addr[`NPD_CHIP_HI:`NPD_CHIP_LO] & address_mask[8*g+7:8*g])
                       == address_match[8*g+7:8*g]);
    end
  endgenerate

  // write data buffer, back-pressure reaches the write channel
  npd_fifo #(.WIDTH(72), .DEPTH(DEPTH), .AW(3)) npd_fifo_i
  (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   ({wr_strb, wr_data}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );
  assign f_strb = f_data[71:64];

  // fifo drains only in address and data steps; a word is left only after
  // its top lane or after the byte that ends the last address cycle
  assign f_ready = f_valid & ((state == ST_ADDR && (byte_idx == 3'h7
                   || (f_strb[byte_idx] && cyc_left == 3'h1)))
                   | (state == ST_DATA && is_write));

  // byte lanes from low address bits
  assign lane_mask = 8'hff << addr[2:0];

  // request accepted at this edge
  assign take = (state == ST_IDLE) && req_valid && !req_ready;

  // incrementing span of the write
  // req_burst is left unread: wrap and fixed count as incrementing
  assign wr_last = req_addr + ((({24'h0, req_len} + 32'h1) << req_size) - 32'h1);
  assign diff    = req_addr ^ wr_last;

  // mask clears up to highest varying bit
  always @*
  begin
    next_mask = 32'hffffffff;
    // highest differing bit wins, as the loop runs upward
    for (k = 0; k < 32; k = k + 1)
      if (diff[k])
        next_mask = 32'hffffffff << (k + 1);
  end

  // pin synchroniser and ready edge
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // line idles high, so no false edge follows reset
      rb_s1            <= 1'b1;
      rb_s2            <= 1'b1;
      rb_d             <= 1'b1;
      raw_ready_status <= 1'b0;
    end
    else
    begin
      rb_s1 <= ready_busy;
      rb_s2 <= rb_s1;
      rb_d  <= rb_s2;
      if (rb_s2 & ~rb_d)
        raw_ready_status <= 1'b1; // set wins over clear
      else if (status_clear)
        raw_ready_status <= 1'b0;
    end
  end

  // region of the last accepted write
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      excl_cmp_mask <= 32'hffffffff;
      excl_cmp_addr <= 32'h0;
    end
    else if (take && req_write)
    begin
      excl_cmp_addr <= req_addr & next_mask;
      excl_cmp_mask <= next_mask;
    end
  end

  // main sequencer
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state           <= ST_IDLE;
      addr            <= 32'h0;
      is_write        <= 1'b0;
      unmapped        <= 1'b0;
      cyc_left        <= 3'h0;
      beats_left      <= 8'h0;
      byte_idx        <= 3'h0;
      held            <= 1'b0;
      req_ready       <= 1'b0;
      resp_valid      <= 1'b0;
      resp_data_phase <= 1'b0;
      resp_unmapped   <= 1'b0;
      nand_cmd_valid  <= 1'b0;
      nand_cmd        <= 8'h0;
      nand_addr_valid <= 1'b0;
      nand_addr       <= 8'h0;
      nand_data_valid <= 1'b0;
      nand_wdata      <= 64'h0;
      nand_strb       <= `NPD_STRB_RESET;
      chip_select     <= {CHIPS{1'b0}};
      if0_async       <= 1'b0;
      bus_request     <= 1'b0;
      ecc_last        <= 1'b0;
    end
    else
    begin
      nand_cmd_valid  <= 1'b0;
      nand_addr_valid <= 1'b0;
      nand_data_valid <= 1'b0;
      resp_valid      <= 1'b0;
      req_ready       <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          bus_request <= held; // keep bus while select held
          if0_async   <= 1'b0;
          // wait for a request; a held select keeps the bus
          if (take)
          begin
            req_ready <= 1'b1;
            addr      <= req_addr;
            is_write  <= req_write;
            unmapped  <= (hit == {CHIPS{1'b0}});
            ecc_last  <= 1'b0;
            beats_left <= req_len + 8'h1;
            if (hit == {CHIPS{1'b0}})
            begin
              // deselected transfer on interface 0
              chip_select <= {CHIPS{1'b0}};
              if0_async   <= 1'b1;
              held        <= 1'b0;
              state       <= ST_DATA;
            end
            else if (!req_addr[`NPD_PHASE_BIT]) // command phase
            begin
              chip_select <= hit;
              bus_request <= 1'b1;
              nand_cmd    <= req_addr[`NPD_START_HI:`NPD_START_LO];
              state       <= ST_CMD;
            end
            else
            begin
              chip_select <= hit;
              bus_request <= 1'b1;
              ecc_last    <= req_addr[`NPD_ECC_LAST_BIT];
              state       <= ST_DATA;
            end
          end
        end
        ST_CMD:
        begin
          // start opcode goes out, cycle count and first lane load
          nand_cmd_valid <= 1'b1;
          cyc_left <= addr[`NPD_CYC_HI:`NPD_CYC_LO]; // zero to seven
          byte_idx <= addr[2:0];
          if (addr[`NPD_CYC_HI:`NPD_CYC_LO] != 3'h0)
            state <= ST_ADDR;
          else if (addr[`NPD_END_VALID_BIT])
            state <= ST_END;
          else
            state <= ST_END;
        end
        ST_ADDR:
        begin
          // one byte per address cycle, in order
          if (f_valid)
          begin
            if (f_strb[byte_idx])
            begin
              nand_addr_valid <= 1'b1;
              nand_addr       <= f_data[8*byte_idx +: 8];
              cyc_left        <= cyc_left - 3'h1;
            end
            byte_idx <= byte_idx + 3'h1;
            if (f_strb[byte_idx] && cyc_left == 3'h1)
              state <= ST_END; // end step after address cycles; second opcode only on flagged writes
          end
        end
        ST_DATA:
        begin
          // one beat per cycle; reads need no buffered word
          if (!is_write || f_valid)
          begin
            nand_data_valid <= 1'b1;
            nand_wdata      <= is_write ? f_data[63:0] : 64'h0;
            // failed exclusive write loses its strobes
            nand_strb  <= req_excl_fail ? 8'h00 : (is_write ? f_strb & lane_mask : lane_mask);
            beats_left <= beats_left - 8'h1;
            if (beats_left == 8'h1)
              state <= (is_write && !unmapped) ? ST_END : ST_IDLE;
            if (beats_left == 8'h1 && (!is_write || unmapped))
            begin
              resp_valid      <= 1'b1;
              resp_data_phase <= 1'b1;
              resp_unmapped   <= unmapped; // okay answer unless unmapped
              if (!unmapped)
                held <= ~addr[`NPD_RELEASE_BIT];
              if (!unmapped && addr[`NPD_RELEASE_BIT])
                chip_select <= {CHIPS{1'b0}};
            end
          end
        end
        ST_END:
        begin
          // trailing opcode only when flagged
          if (addr[`NPD_END_VALID_BIT] && is_write)
          begin
            nand_cmd_valid <= 1'b1;
            nand_cmd       <= addr[`NPD_END_HI:`NPD_END_LO];
          end
          resp_valid      <= 1'b1;
          resp_data_phase <= addr[`NPD_PHASE_BIT];
          resp_unmapped   <= 1'b0;
          state           <= ST_IDLE;
          if (!addr[`NPD_PHASE_BIT])
          begin
            held <= hold_select; // select kept into data phase
            if (!hold_select)
              chip_select <= {CHIPS{1'b0}};
          end
          else
          begin
            held <= ~addr[`NPD_RELEASE_BIT];
            if (addr[`NPD_RELEASE_BIT])
              chip_select <= {CHIPS{1'b0}};
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: npd_flash_model.sv */
/*
  two flash devices sharing one wired-and ready line.
  assumes a start pulse from the bench on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module npd_flash_model
#(
  parameter BUSY0 = 8,
  parameter BUSY1 = 25
)
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // operation start and shared line
  input  wire logic busy_start,
  output wire logic ready_busy
);
  int cnt;
  // elapsed cycles since the last start
  always @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      cnt <= 999;
    else if (busy_start)
      cnt <= 0;
    else if (cnt < 999)
      cnt <= cnt + 1;
  // line rises only once both devices are done
  assign ready_busy = (cnt >= BUSY0) & (cnt >= BUSY1);
endmodule
`default_nettype wire

/* File: npd_properties.sv */
/*
  concurrent checks on the decoder ports.
  assumes chip 0 in the low byte of the tie-offs.
*/
`timescale 1ns/1ps
`default_nettype none
module npd_properties
#(
  parameter CHIPS = 2
)
(
  input wire logic               sys_clk,
  input wire logic               rst_n,
  input wire logic [8*CHIPS-1:0] address_match,
  input wire logic [8*CHIPS-1:0] address_mask,
  input wire logic               req_ready,
  input wire logic [31:0]        req_addr,
  input wire logic               req_excl_fail,
  input wire logic               resp_valid,
  input wire logic               nand_cmd_valid,
  input wire logic [7:0]         nand_cmd,
  input wire logic               nand_data_valid,
  input wire logic [7:0]         nand_strb,
  input wire logic [CHIPS-1:0]   chip_select,
  input wire logic               if0_async,
  input wire logic               bus_request,
  input wire logic               ready_busy,
  input wire logic               raw_ready_status
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  cmd_opcode_a:
    assert property (req_ready && !req_addr[19] && !if0_async |=> nand_cmd_valid
      && nand_cmd == $past(req_addr[10:3])) else $error("start opcode wrong");
  data_nocmd_a:
    assert property (req_ready && req_addr[19] |=> !nand_cmd_valid)
      else $error("opcode in data phase");
  end_cmd_a:
    assert property (req_ready && !req_addr[19] && req_addr[23:21] == 3'h0 && !if0_async
      |-> ##2 resp_valid && nand_cmd_valid == $past(req_addr[20], 2))
      else $error("end opcode timing wrong");
  chip_match_a:
    assert property (req_ready && (req_addr[31:24] & address_mask[7:0])
      == address_match[7:0] |-> chip_select[0]) else $error("chip not selected");
  unmapped_cs_a:
    assert property (if0_async |-> chip_select == '0) else $error("select on unmapped");
  excl_strb_a:
    assert property (nand_data_valid && $past(req_excl_fail) |-> nand_strb == 8'h00)
      else $error("strobes on failed write");
  bus_hold_a:
    assert property ($past(chip_select) != '0 && chip_select != '0 |-> bus_request)
      else $error("bus dropped while held");
  ready_rise_a:
    assert property ($rose(ready_busy) |-> ##[1:4] raw_ready_status)
      else $error("ready edge not seen");
  cover property (if0_async);
  cover property (resp_valid && nand_cmd_valid);
  cover property (raw_ready_status);
endmodule
bind npd_decoder npd_properties #(.CHIPS(CHIPS)) npd_properties_i (.sys_clk(sys_clk),
  .rst_n(rst_n), .address_match(address_match), .address_mask(address_mask),
  .req_ready(req_ready), .req_addr(req_addr), .req_excl_fail(req_excl_fail),
  .resp_valid(resp_valid), .nand_cmd_valid(nand_cmd_valid), .nand_cmd(nand_cmd),
  .nand_data_valid(nand_data_valid), .nand_strb(nand_strb), .chip_select(chip_select),
  .if0_async(if0_async), .bus_request(bus_request), .ready_busy(ready_busy),
  .raw_ready_status(raw_ready_status));
`default_nettype wire

/* File: npd_decoder_bench.sv */
/*
  bench for the nand phase decoder: request sequences and checks.
  assumes the checker binds itself and the flash model drives busy.
*/
`timescale 1ns/1ps
`default_nettype none
module npd_decoder_bench;
  // driven and observed signals
  logic        sys_clk, rst_n, hold_select, req_valid, req_write, req_excl_fail;
  logic        wr_valid, status_clear, busy_start, rv, el, un, ia;
  logic [31:0] req_addr;
  logic [7:0]  req_len, wr_strb, ls, cq[$], aq[$];
  logic [2:0]  req_size;
  logic [1:0]  req_burst;
  logic [63:0] wr_data, lw;
  wire         req_ready, wr_ready, resp_valid, resp_data_phase, resp_unmapped;
  wire         nand_cmd_valid, nand_addr_valid, nand_data_valid, if0_async;
  wire         bus_request, ecc_last, ready_busy, raw_ready_status;
  wire [7:0]   nand_cmd, nand_addr, nand_strb;
  wire [63:0]  nand_wdata;
  wire [1:0]   chip_select;
  wire [31:0]  excl_cmp_mask, excl_cmp_addr;
  int          dn, k, i, num_errors, comparisons;
  npd_decoder #(.CHIPS(2), .DEPTH(8)) npd_decoder_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .address_match(16'h2010), .address_mask(16'hf0f0), .hold_select(hold_select),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_len(req_len), .req_size(req_size), .req_burst(req_burst),
    .req_excl_fail(req_excl_fail), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .wr_strb(wr_strb), .resp_valid(resp_valid),
    .resp_data_phase(resp_data_phase), .resp_unmapped(resp_unmapped),
    .nand_cmd_valid(nand_cmd_valid), .nand_cmd(nand_cmd),
    .nand_addr_valid(nand_addr_valid), .nand_addr(nand_addr),
    .nand_data_valid(nand_data_valid), .nand_wdata(nand_wdata), .nand_strb(nand_strb),
    .chip_select(chip_select), .if0_async(if0_async), .bus_request(bus_request),
    .ecc_last(ecc_last), .ready_busy(ready_busy), .raw_ready_status(raw_ready_status),
    .status_clear(status_clear), .excl_cmp_mask(excl_cmp_mask),
    .excl_cmp_addr(excl_cmp_addr));
  npd_flash_model npd_flash_model_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .busy_start(busy_start), .ready_busy(ready_busy));
  // 40 mhz clock
  initial
  begin
    sys_clk = 0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // record what the decoder sends toward the flash
  always @(posedge sys_clk)
  begin
    if (nand_cmd_valid) cq.push_back(nand_cmd);
    if (nand_addr_valid) aq.push_back(nand_addr);
    if (nand_data_valid) dn++;
    if (nand_data_valid) ls = nand_strb;
    if (nand_data_valid) lw = nand_wdata;
    if (if0_async) ia = 1;
    if (resp_valid) rv = 1;
    if (ecc_last) el = 1;
    if (resp_valid && resp_unmapped) un = 1;
  end
  function automatic logic [31:0] mk(input logic [7:0] t, input logic [2:0] c,
    input logic v, input logic p, input logic [7:0] e, input logic [7:0] s);
    mk = {t, c, v, p, e, s, 3'h0};
  endfunction
  task chk(input string n, input logic [63:0] e, input logic [63:0] g);
  begin
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  end
  endtask
  task wrap_up;
  begin
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  // one write data word into the fifo
  task push(input logic [63:0] d, input logic [7:0] s, input logic rdy);
  begin
    @(negedge sys_clk);
    chk("wr_ready", rdy, wr_ready);
    wr_valid = 1;
    wr_data = d;
    wr_strb = s;
    @(negedge sys_clk);
    wr_valid = 0;
  end
  endtask
  // one request, held until taken, then wait for the answer
  task run(input logic w, input logic [31:0] a, input logic [7:0] ln);
  begin
    @(negedge sys_clk);
    cq = {};
    aq = {};
    dn = 0;
    rv = 0;
    el = 0;
    un = 0;
    ia = 0;
    req_write = w;
    req_addr = a;
    req_len = ln;
    req_valid = 1;
    for (k = 0; k < 30 && req_ready !== 1'b1; k++) @(negedge sys_clk);
    req_valid = 0;
    for (k = 0; k < 60 && !rv; k++) @(negedge sys_clk);
    if (!rv) num_errors++;
    if (!rv) wrap_up;
    repeat (2) @(negedge sys_clk);
  end
  endtask
  initial
  begin
    {rst_n, hold_select, req_valid, req_write, req_excl_fail} = 0;
    {wr_valid, status_clear, busy_start, req_addr, req_len, wr_data, wr_strb} = 0;
    req_size = 3'h3;
    req_burst = 2'h1;
    repeat (6) @(negedge sys_clk);
    rst_n = 1;
    // command, three address bytes, end opcode
    push(64'h0000_0000_0011_2233, 8'h07, 1);
    run(1, mk(8'h10, 3'h3, 1, 0, 8'h30, 8'h80), 0);
    chk("start", 8'h80, cq[0]);
    chk("end", 8'h30, cq[1]);
    chk("addr0", 8'h33, aq[0]);
    chk("addr2", 8'h11, aq[2]);
    chk("cs free", 2'h0, chip_select);
    chk("phase", 0, resp_data_phase);
    // seven address bytes, end opcode not flagged
    push(64'h0007_0605_0403_0201, 8'h7f, 1);
    run(1, mk(8'h10, 3'h7, 0, 0, 8'h55, 8'h60), 0);
    for (i = 0; i < 7; i++) chk("addr", i + 1, aq[i]);
    chk("cmds", 1, cq.size());
    // held select across command and data phases
    hold_select = 1;
    run(1, mk(8'h10, 3'h0, 0, 0, 8'h00, 8'h00), 0);
    chk("cs held", 2'h1, chip_select);
    chk("bus", 1, bus_request);
    push(64'hdead_beef_0123_4567, 8'hff, 1);
    run(1, mk(8'h10, 3'h0, 1, 1, 8'h10, 8'h00), 0);
    chk("beats", 1, dn);
    chk("program", 8'h10, cq[0]);
    chk("wdata", 64'hdead_beef_0123_4567, lw);
    chk("cs kept", 2'h1, chip_select);
    run(0, mk(8'h10, 3'h1, 0, 1, 8'h00, 8'h80), 0);
    chk("ecc last", 1, el);
    chk("phase", 1, resp_data_phase);
    chk("cs off", 2'h0, chip_select);
    hold_select = 0;
    // failed exclusive wrapping write
    req_excl_fail = 1;
    req_size = 3'h2;
    req_burst = 2'h2;
    push(64'h1, 8'hff, 1);
    push(64'h2, 8'hff, 1);
    run(1, 32'h1028_0104, 1);
    chk("strb", 8'h00, ls);
    chk("mask", 32'hffff_fff0, excl_cmp_mask);
    chk("region", 32'h1028_0100, excl_cmp_addr);
    req_excl_fail = 0;
    req_size = 3'h3;
    req_burst = 2'h1;
    // fill the fifo until refused, drain by an eight beat write
    for (i = 0; i < 9; i++) push(i, 8'hff, i < 8);
    run(1, mk(8'h20, 3'h1, 0, 1, 8'h00, 8'h00), 7);
    chk("drain", 8, dn);
    chk("wr_ready", 1, wr_ready);
    chk("cs off", 2'h0, chip_select);
    // status read: short command write, then one byte read
    run(1, mk(8'h10, 3'h0, 0, 0, 8'h00, 8'h70), 0);
    chk("status cmd", 8'h70, cq[0]);
    chk("status cmds", 1, cq.size());
    req_size = 3'h0;
    run(0, mk(8'h10, 3'h1, 0, 1, 8'h00, 8'h00), 0);
    chk("status beat", 1, dn);
    chk("status cs", 2'h0, chip_select);
    chk("status phase", 1, resp_data_phase);
    req_size = 3'h3;
    // access selecting no chip, with its one write word buffered
    push(64'h0, 8'hff, 1);
    run(1, mk(8'hff, 3'h0, 0, 0, 8'h00, 8'h70), 0);
    chk("unmapped", 1, un);
    chk("if0", 1, ia);
    chk("unmapped cs", 2'h0, chip_select);
    // ready line rises only when both devices finish
    @(negedge sys_clk);
    busy_start = 1;
    @(negedge sys_clk);
    busy_start = 0;
    repeat (10) @(negedge sys_clk);
    chk("raw busy", 0, raw_ready_status);
    repeat (30) @(negedge sys_clk);
    chk("raw ready", 1, raw_ready_status);
    status_clear = 1;
    @(negedge sys_clk);
    status_clear = 0;
    @(negedge sys_clk);
    chk("raw clear", 0, raw_ready_status);
    wrap_up;
  end
endmodule
`default_nettype wire
